/* pkg/seg_vec_defs.svh */
// Overview of operation
// - Aux execution vectors all but address error to 0x7FFFFA
// - Address error always vectors to 0x000006
// - Unprotected aux reset select runs application
// - Select 0 without aux protection fetches reset from 0x7FFFFC
// - Select 0 with aux protection forces reset
// - Nesting disable bit blocks interrupt preemption of a handler; traps still preempt
// - Temporary mask covers priorities up to 6
// - Latency bit: 1 variable, 0 fixed
`ifndef SEG_VEC_DEFS_SVH
`define SEG_VEC_DEFS_SVH
// Vector addresses (24-bit program space)
`define AUX_VEC_ADDR      24'h7ffffa
`define ADDR_ERR_VEC_ADDR 24'h000006
`define AUX_RESET_ADDR    24'h7ffffc
`define GEN_RESET_ADDR    24'h000000
`define GEN_IVT_BASE      24'h000008
// Register byte offsets
`define OFS_INT_CTRL1     12'h000
`define OFS_CORE_CTRL     12'h004
`define OFS_STATUS        12'h008
`define OFS_LOOP_COUNT    12'h00c
// Field positions
`define BIT_NEST_DIS      15
`define BIT_VAR_LAT       15
// Priorities and latency counts (cycles minus one)
`define TEMP_MASK_MAX_PRIO 4'h6
`define TRAP_PRIO         4'h8
`define LAT_FIXED_LOAD    4'h3
`define LAT_VAR_LOAD      4'h0
`define BOOT_SETTLE       2'h3
`define CNT_W             14
`endif

/* pkg/seg_vec_pkg.sv */
`include "seg_vec_defs.svh"
package seg_vec_pkg;
  // Sequencer states
  typedef enum logic [2:0] {ST_BOOT_WAIT, ST_RUN, ST_LAT, ST_HALT} seq_state_t;
  // Whole state of the unit
  typedef struct packed {
    logic             rsv_s1;
    logic             rsv_s2;
    logic             ap_s1;
    logic             ap_s2;
    seq_state_t       state;
    logic [1:0]       boot_cnt;
    logic             cfg_rsv;
    logic             cfg_ap;
    logic [3:0]       lat_cnt;
    logic [23:0]      pend_addr;
    logic [3:0]       pend_prio;
    logic             nest_dis;
    logic             var_lat;
    logic             active;
    logic [3:0]       cur_prio;
    logic [`CNT_W-1:0] tmask_cnt;
    logic [`CNT_W-1:0] loop_cnt;
    logic             loop_done;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             vec_valid;
    logic [23:0]      vec_addr;
    logic             boot_valid;
    logic [23:0]      boot_addr;
    logic             dev_reset_req;
  } seg_state_t;
endpackage

/* rtl/segment_vector_and_nesting_control.sv */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "seg_vec_defs.svh"
module segment_vector_and_nesting_control
  import seg_vec_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Configuration pins
  input  wire logic               cfg_reset_vector_select,
  input  wire logic               aux_segment_protect_config,
  // Core exception requests
  input  wire logic               exec_in_aux,
  input  wire logic               irq_req,
  input  wire logic [3:0]         irq_prio,
  input  wire logic [6:0]         irq_vec_num,
  input  wire logic               trap_req,
  input  wire logic               trap_addr_err,
  input  wire logic [6:0]         trap_vec_num,
  input  wire logic               exc_return,
  // Temporary mask instruction
  input  wire logic               temp_mask_instr,
  input  wire logic [`CNT_W-1:0]  temp_mask_cycles,
  // Hardware loop
  input  wire logic               loop_load,
  input  wire logic [`CNT_W-1:0]  loop_load_val,
  input  wire logic               loop_iter_start,
  input  wire logic               loop_iter_end,
  // Vector and boot outputs
  output logic                    vec_valid,
  output logic      [23:0]        vec_addr,
  output logic                    boot_valid,
  output logic      [23:0]        boot_addr,
  output logic                    dev_reset_req,
  output logic      [`CNT_W-1:0]  hw_loop_count
);

  seg_state_t s_ff;          // Registered state
  seg_state_t nxt_s;         // Next state
  logic       take_trap;     // Trap accepted this cycle
  logic       take_irq;      // Interrupt accepted this cycle
  logic       tmask_on;      // Temporary mask in effect
  logic       apb_wr;        // Write strobe at access edge
  logic [23:0] gen_irq_addr; // General-segment interrupt entry
  logic [23:0] gen_trap_addr;// General-segment trap entry

  // Acceptance decisions
  assign tmask_on  = (s_ff.tmask_cnt != '0);
  assign take_trap = (s_ff.state == ST_RUN) && trap_req;
  assign take_irq  = (s_ff.state == ST_RUN) && irq_req && !trap_req
                     && (irq_prio > s_ff.cur_prio)
                     && !(s_ff.active && s_ff.nest_dis)
                     && !(tmask_on && irq_prio <= `TEMP_MASK_MAX_PRIO);
  assign apb_wr    = psel && penable && s_ff.pready && pwrite;
  assign gen_irq_addr  = `GEN_IVT_BASE + {16'h0000, irq_vec_num, 1'b0};
  assign gen_trap_addr = {16'h0000, trap_vec_num, 1'b0};

  // Next-state logic
  always_comb begin
    nxt_s = s_ff;
    // Pin synchronisers
    nxt_s.rsv_s1 = cfg_reset_vector_select;
    nxt_s.rsv_s2 = s_ff.rsv_s1;
    nxt_s.ap_s1  = aux_segment_protect_config;
    nxt_s.ap_s2  = s_ff.ap_s1;
    // Pulses default low
    nxt_s.vec_valid     = 1'b0;
    nxt_s.dev_reset_req = 1'b0;
    // Temporary mask countdown
    if (temp_mask_instr) begin
      nxt_s.tmask_cnt = temp_mask_cycles;
    end else if (tmask_on) begin
      nxt_s.tmask_cnt = s_ff.tmask_cnt - 1'b1;
    end
    // Hardware loop counter, once per iteration
    if (loop_load) begin
      nxt_s.loop_cnt  = loop_load_val;
      nxt_s.loop_done = 1'b0;
    end else if (loop_iter_end && !s_ff.loop_done) begin
      nxt_s.loop_cnt  = s_ff.loop_cnt - 1'b1;
      nxt_s.loop_done = 1'b1;
    end else if (loop_iter_start) begin
      nxt_s.loop_done = 1'b0;
    end
    // Sequencer
    case (s_ff.state)
      ST_BOOT_WAIT: begin
        // Let the synchronisers settle before sampling straps
        if (s_ff.boot_cnt == `BOOT_SETTLE) begin
          nxt_s.cfg_rsv = s_ff.rsv_s2;
          nxt_s.cfg_ap  = s_ff.ap_s2;
          if (!s_ff.rsv_s2 && s_ff.ap_s2) begin
            nxt_s.dev_reset_req = 1'b1;
            nxt_s.state         = ST_HALT;
          end else begin
            nxt_s.boot_valid = 1'b1;
            nxt_s.boot_addr  = s_ff.rsv_s2 ? `GEN_RESET_ADDR
                                           : `AUX_RESET_ADDR;
            nxt_s.state      = ST_RUN;
          end
        end else begin
          nxt_s.boot_cnt = s_ff.boot_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        if (take_trap) begin
          // Address error ignores the aux routing
          if (trap_addr_err) begin
            nxt_s.pend_addr = `ADDR_ERR_VEC_ADDR;
          end else if (exec_in_aux) begin
            nxt_s.pend_addr = `AUX_VEC_ADDR;
          end else begin
            nxt_s.pend_addr = gen_trap_addr;
          end
          nxt_s.pend_prio = `TRAP_PRIO;
          nxt_s.lat_cnt   = s_ff.var_lat ? `LAT_VAR_LOAD : `LAT_FIXED_LOAD;
          nxt_s.state     = ST_LAT;
        end else if (take_irq) begin
          nxt_s.pend_addr = exec_in_aux ? `AUX_VEC_ADDR : gen_irq_addr;
          nxt_s.pend_prio = irq_prio;
          nxt_s.lat_cnt   = s_ff.var_lat ? `LAT_VAR_LOAD : `LAT_FIXED_LOAD;
          nxt_s.state     = ST_LAT;
        end else if (exc_return) begin
          // Single-level tracking: return drops to thread level
          nxt_s.active   = 1'b0;
          nxt_s.cur_prio = 4'h0;
        end
      end
      ST_LAT: begin
        // Exception processing delay, then hand out the vector
        if (s_ff.lat_cnt == 4'h0) begin
          nxt_s.vec_valid = 1'b1;
          nxt_s.vec_addr  = s_ff.pend_addr;
          nxt_s.active    = 1'b1;
          nxt_s.cur_prio  = s_ff.pend_prio;
          nxt_s.state     = ST_RUN;
        end else begin
          nxt_s.lat_cnt = s_ff.lat_cnt - 1'b1;
        end
      end
      ST_HALT: begin
        // Security trap: wait for the device reset
        nxt_s.state = ST_HALT;
      end
      default: begin
        nxt_s.state = ST_BOOT_WAIT;
      end
    endcase
    // APB: answer in the access phase, zero wait states
    nxt_s.pready  = psel && !penable;
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        `OFS_INT_CTRL1:  nxt_s.prdata[`BIT_NEST_DIS] = s_ff.nest_dis;
        `OFS_CORE_CTRL:  nxt_s.prdata[`BIT_VAR_LAT]  = s_ff.var_lat;
        `OFS_STATUS:     nxt_s.prdata[11:0] = {s_ff.cfg_ap, s_ff.cfg_rsv,
                                               s_ff.state == ST_HALT, tmask_on,
                                               s_ff.active, s_ff.pend_prio[2:0],
                                               s_ff.cur_prio};
        `OFS_LOOP_COUNT: nxt_s.prdata[`CNT_W-1:0] = s_ff.loop_cnt;
        default:         nxt_s.pslverr = 1'b1;
      endcase
    end
    // Register writes
    if (apb_wr && paddr == `OFS_INT_CTRL1) begin
      nxt_s.nest_dis = pwdata[`BIT_NEST_DIS];
    end
    if (apb_wr && paddr == `OFS_CORE_CTRL) begin
      nxt_s.var_lat = pwdata[`BIT_VAR_LAT];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flops
  assign prdata        = s_ff.prdata;
  assign pready        = s_ff.pready;
  assign pslverr       = s_ff.pslverr;
  assign vec_valid     = s_ff.vec_valid;
  assign vec_addr      = s_ff.vec_addr;
  assign boot_valid    = s_ff.boot_valid;
  assign boot_addr     = s_ff.boot_addr;
  assign dev_reset_req = s_ff.dev_reset_req;
  assign hw_loop_count = s_ff.loop_cnt;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_take_fixed;
    (take_irq || take_trap) && !s_ff.var_lat;
  endsequence
  sequence seq_take_var;
    (take_irq || take_trap) && s_ff.var_lat;
  endsequence

  AST_AUX_VECTOR: assert property (take_irq && exec_in_aux |-> ##[2:5]
    (vec_valid && vec_addr == `AUX_VEC_ADDR))
    else $error("aux interrupt not routed to shared entry");
  AST_ADDR_ERR_VECTOR: assert property (take_trap && trap_addr_err |-> ##[2:5]
    (vec_valid && vec_addr == `ADDR_ERR_VEC_ADDR))
    else $error("address error trap entry wrong");
  AST_BOOT_RUNS: assert property ($rose(boot_valid) |->
    !(!s_ff.cfg_rsv && s_ff.cfg_ap) && s_ff.state == ST_RUN)
    else $error("boot without valid configuration");
  AST_BOOT_ADDR: assert property ($rose(boot_valid) |->
    boot_addr == (s_ff.cfg_rsv ? `GEN_RESET_ADDR : `AUX_RESET_ADDR))
    else $error("reset fetch address wrong");
  AST_SECURE_RESET: assert property ($rose(dev_reset_req) |->
    !s_ff.cfg_rsv && s_ff.cfg_ap && !boot_valid ##1 !dev_reset_req)
    else $error("security reset without cause");
  // Running handler with nesting off: the sequencer must stay in run
  AST_NO_NEST: assert property (s_ff.active && s_ff.nest_dis && !trap_req
    && s_ff.state == ST_RUN |=> s_ff.state == ST_RUN)
    else $error("preemption while nesting disabled");
  // Masked priority pending alone: no exception entry may start
  AST_TEMP_MASK: assert property (tmask_on && irq_req && !trap_req
    && irq_prio <= `TEMP_MASK_MAX_PRIO && s_ff.state == ST_RUN |=> s_ff.state == ST_RUN)
    else $error("masked priority taken");
  // Vector rises on the fourth edge after the take edge
  AST_FIXED_LAT: assert property (seq_take_fixed |-> ##1 !vec_valid [*4] ##1 vec_valid)
    else $error("fixed latency not five cycles");
  AST_VAR_LAT: assert property (seq_take_var |-> ##2 vec_valid)
    else $error("variable latency not two cycles");
  AST_LOOP_ONCE: assert property (loop_iter_end && s_ff.loop_done && !loop_load |=>
    hw_loop_count == $past(hw_loop_count))
    else $error("loop count decremented twice");

endmodule // segment_vector_and_nesting_control
`default_nettype wire

/* testbench/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock
  input  wire logic        pclk,
  // Vector answer
  input  wire logic        vec_valid,
  input  wire logic [23:0] vec_addr,
  // Exception requests
  output logic             exec_in_aux,
  output logic             irq_req,
  output logic [3:0]       irq_prio,
  output logic [6:0]       irq_vec_num,
  output logic             trap_req,
  output logic             trap_addr_err,
  output logic [6:0]       trap_vec_num,
  output logic             exc_return
);
  logic want_irq;  // Interrupt pending
  logic want_trap; // Trap pending
  // Drop request in the cycle the vector is handed over
  assign irq_req  = want_irq & ~vec_valid;
  assign trap_req = want_trap & ~vec_valid;
  initial begin
    {exec_in_aux, want_irq, want_trap, trap_addr_err, exc_return} = 5'h00;
    {irq_prio, irq_vec_num, trap_vec_num} = 18'h00000;
  end
  // Hold one request until answered or given up
  task automatic request(input logic aux, input logic trap, input logic ae,
      input logic [3:0] prio, input logic [6:0] num, output logic taken,
      output int lat, output logic [23:0] addr);
    taken = 1'b0;
    lat = 0;
    addr = 24'h000000;
    @(posedge pclk);
    exec_in_aux <= aux;
    want_irq <= ~trap;
    want_trap <= trap;
    trap_addr_err <= ae;
    irq_prio <= prio;
    irq_vec_num <= num;
    trap_vec_num <= num;
    while (!taken && lat < 20) begin
      @(posedge pclk);
      lat++;
      if (vec_valid === 1'b1) begin
        taken = 1'b1;
        addr = vec_addr;
      end
    end
    want_irq <= 1'b0;
    want_trap <= 1'b0;
    // Released qualifiers flip so stale values never look valid
    irq_vec_num <= ~num;
    trap_vec_num <= ~num;
    trap_addr_err <= ~ae;
  endtask
  // Handler return strobe
  task automatic ret();
    @(posedge pclk);
    exc_return <= 1'b1;
    @(posedge pclk);
    exc_return <= 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "seg_vec_defs.svh"
module testbench;
  // Clock, reset and score
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  int                err_total = 0;
  int                n_tests = 0;
  // APB and strap inputs
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata, rd;
  logic              cfg_sel = 1'b1, cfg_prot = 1'b0, tmi = 1'b0, ld = 1'b0;
  logic              it_s = 1'b0, it_e = 1'b0, er, tk;
  logic [`CNT_W-1:0] tmc = '0, ld_val = '0, hw_loop_count;
  // Exception lines
  logic              exec_in_aux, irq_req, trap_req, trap_addr_err, exc_return;
  logic              vec_valid, boot_valid, dev_reset_req;
  logic [3:0]        irq_prio;
  logic [6:0]        irq_vec_num, trap_vec_num, num;
  logic [23:0]       vec_addr, boot_addr, ad;
  int                lat, lat_f, v;
  always #12.5 pclk = ~pclk;
  segment_vector_and_nesting_control segment_vector_and_nesting_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_reset_vector_select(cfg_sel), .aux_segment_protect_config(cfg_prot),
    .exec_in_aux(exec_in_aux), .irq_req(irq_req), .irq_prio(irq_prio),
    .irq_vec_num(irq_vec_num), .trap_req(trap_req), .trap_addr_err(trap_addr_err),
    .trap_vec_num(trap_vec_num), .exc_return(exc_return), .temp_mask_instr(tmi),
    .temp_mask_cycles(tmc), .loop_load(ld), .loop_load_val(ld_val), .loop_iter_start(it_s),
    .loop_iter_end(it_e), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .boot_valid(boot_valid), .boot_addr(boot_addr), .dev_reset_req(dev_reset_req),
    .hw_loop_count(hw_loop_count));
  core_model core_model_i (
    .pclk(pclk), .vec_valid(vec_valid), .vec_addr(vec_addr), .exec_in_aux(exec_in_aux),
    .irq_req(irq_req), .irq_prio(irq_prio), .irq_vec_num(irq_vec_num), .trap_req(trap_req),
    .trap_addr_err(trap_addr_err), .trap_vec_num(trap_vec_num), .exc_return(exc_return));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Expected vector from segment, kind and number
  function automatic logic [23:0] exp_vec(logic aux, logic trap, logic ae, logic [6:0] n);
    if (trap && ae) return 24'h000006;
    if (aux) return 24'h7ffffa;
    return trap ? {16'h0000, n, 1'b0} : `GEN_IVT_BASE + {16'h0000, n, 1'b0};
  endfunction
  // One APB transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] d, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // One-cycle strobe on a core-side input
  task automatic strobe(input int k);
    @(posedge pclk);
    case (k)
      0: ld <= 1'b1;
      1: it_s <= 1'b1;
      2: it_e <= 1'b1;
      default: tmi <= 1'b1;
    endcase
    @(posedge pclk);
    {ld, it_s, it_e, tmi} <= 4'h0;
    @(posedge pclk);
  endtask
  // Reset with given straps, then watch the boot decision
  task automatic do_reset(input logic s, input logic p);
    int seen;
    seen = 0;
    @(posedge pclk);
    {presetn, cfg_sel, cfg_prot} <= {1'b0, s, p};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) begin
      @(posedge pclk);
      if (dev_reset_req === 1'b1) seen++;
    end
    chk(32'(seen), 32'(!s && p));
    chk(32'(boot_valid), 32'(s || !p));
    if (s || !p) chk(32'(boot_addr), s ? 32'h0 : 32'h7ffffc);
  endtask
  initial begin
    #750us;
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(65));
    do_reset(1'b0, 1'b1);
    do_reset(1'b1, 1'b0);
    do_reset(1'b0, 1'b0);
    // Control bits read back, unmapped place refused
    for (int a = 0; a < 8; a += 4) begin
      apb(1'b1, 12'(a), 32'h8000, rd, er);
      apb(1'b0, 12'(a), 32'h0, rd, er);
      chk(rd & 32'h8000, 32'h8000);
    end
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h004, 32'h0, rd, er);
    // Vector per segment and kind
    for (int i = 0; i < 6; i++) begin
      num = 7'($urandom_range(127, 0));
      core_model_i.request(i inside {[1:3]}, i >= 2, i == 2 || i == 5, 4'h3, num, tk, lat, ad);
      if (i == 0) lat_f = lat;
      chk(32'(ad), 32'(exp_vec(i inside {[1:3]}, i >= 2, i == 2 || i == 5, num)));
      core_model_i.ret();
    end
    // Variable latency is three cycles shorter
    apb(1'b1, 12'h004, 32'h8000, rd, er);
    core_model_i.request(1'b0, 1'b0, 1'b0, 4'h3, num, tk, lat, ad);
    chk(32'(lat_f - lat), 32'd3);
    chk(32'(lat_f), 32'd6);
    core_model_i.ret();
    apb(1'b1, 12'h004, 32'h0, rd, er);
    // Preemption blocked, then allowed
    for (int nd = 1; nd >= 0; nd--) begin
      apb(1'b1, 12'h000, nd != 0 ? 32'h8000 : 32'h0, rd, er);
      core_model_i.request(1'b0, 1'b0, 1'b0, 4'h3, num, tk, lat, ad);
      core_model_i.request(1'b0, 1'b0, 1'b0, 4'h5, num, tk, lat, ad);
      chk(32'(tk), 32'(nd == 0));
      core_model_i.ret();
    end
    // Loop count drops once per iteration
    v = $urandom_range(200, 3);
    ld_val <= 14'(v);
    strobe(0);
    chk(32'(hw_loop_count), 32'(v));
    strobe(2);
    strobe(2);
    chk(32'(hw_loop_count), 32'(v - 1));
    strobe(1);
    strobe(2);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk(rd, 32'(v - 2));
    // Temporary mask holds back priority 6, lets 7 through
    tmc <= 14'd300;
    strobe(3);
    for (int p = 6; p < 8; p++) begin
      core_model_i.request(1'b0, 1'b0, 1'b0, 4'(p), num, tk, lat, ad);
      chk(32'(tk), 32'(p == 7));
    end
    core_model_i.ret();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
